//--- hw/opm_ctrl.v
// Oscillator control and operating-mode logic with AXI4-Lite registers
`timescale 1ns/1ps
`include "opm_map.vh"

module opm_ctrl #(
    parameter XTAL_STABLE_CYC = 1024,
    parameter FAST_STABLE_CYC = 16,
    parameter SLOW_STABLE_CYC = 2,
    parameter CNT_W = 11
) (
    input wire aclk,
    input wire aresetn,
    input wire [`OPM_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`OPM_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire halt_exec,
    input wire wake_req,
    input wire fast_freq_change,
    input wire watchdog_enable,
    input wire watchdog_timeout,
    input wire watchdog_clear_cmd,
    input wire fsub_tick,
    output reg crystal_osc_enable_r,
    output reg fast_internal_osc_enable_r,
    output reg slow_internal_osc_enable_r,
    output reg fh_run_r,
    output reg fsub_run_r,
    output reg sys_clk_en_r,
    output reg cpu_hold_r,
    output reg watchdog_counter_clear_r,
    output reg sys_from_slow_r
);
    localparam [6:0] ST_NORMAL = 7'h01;
    localparam [6:0] ST_SLOW = 7'h02;
    localparam [6:0] ST_SLEEP = 7'h04;
    localparam [6:0] ST_IDLE_SLOW_CLOCK_ONLY = 7'h08;
    localparam [6:0] ST_IDLE_BOTH_CLOCKS = 7'h10;
    localparam [6:0] ST_IDLE2 = 7'h20;
    localparam [6:0] ST_WAKE = 7'h40;
    localparam [CNT_W-1:0] XTAL_N = XTAL_STABLE_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] FAST_N = FAST_STABLE_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] SLOW_N = SLOW_STABLE_CYC[CNT_W-1:0];

    // Stabilisation counter step: restart when off or restarted, saturate at n
    function [CNT_W-1:0] osc_step;
        input [CNT_W-1:0] cnt;
        input on;
        input restart;
        input [CNT_W-1:0] n;
        begin
            if (!on || restart)
                osc_step = {CNT_W{1'b0}};
            else if (cnt < n)
                osc_step = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            else
                osc_step = cnt;
        end
    endfunction

    reg [6:0] state_r;
    reg [6:0] state_nxt;
    reg xtal_en_r;
    reg fast_en_r;
    reg ls_idle_r;
    reg hs_idle_r;
    reg hs_xtal_r;
    reg [2:0] sel_r;
    reg pdf_r;
    reg to_r;
    reg [CNT_W-1:0] xtal_cnt_r;
    reg [CNT_W-1:0] fast_cnt_r;
    reg [CNT_W-1:0] slow_cnt_r;
    reg xtal_restart;
    reg [`OPM_ADDR_W-1:0] wr_addr_r;
    reg [7:0] wr_data_r;
    reg wr_go_r;
    wire xtal_stable;
    wire fast_stable;
    wire slow_stable;
    wire hs_stable;
    wire fh_on;
    wire fsub_on;
    wire div_tick;
    wire enter_pd;
    wire aw_take;
    wire ar_take;

    assign xtal_stable = fh_on && xtal_en_r && (xtal_cnt_r >= XTAL_N);
    assign fast_stable = fh_on && fast_en_r && (fast_cnt_r >= FAST_N);
    assign slow_stable = slow_cnt_r >= SLOW_N;
    assign hs_stable = hs_xtal_r ? xtal_stable : fast_stable;
    // fH stops in sleep and slow-clock idle only
    assign fh_on = !(state_r[2] || state_r[3]);
    assign fsub_on = !state_r[2] && !state_r[5];
    assign enter_pd = ((state_r == ST_NORMAL) || (state_r == ST_SLOW)) && halt_exec;

    ////////////////////////////////////////////////////////////////////////////
    // Mode state machine
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL: begin
                if (halt_exec)
                    state_nxt = ST_SLEEP;
                else if (sel_r == `OPM_SEL_SLOW && slow_stable)
                    state_nxt = ST_SLOW;
            end
            ST_SLOW: begin
                if (halt_exec)
                    state_nxt = ST_SLEEP;
                else if (sel_r != `OPM_SEL_SLOW)
                    state_nxt = ST_NORMAL;
            end
            ST_SLEEP, ST_IDLE_SLOW_CLOCK_ONLY, ST_IDLE_BOTH_CLOCKS, ST_IDLE2: begin
                if (wake_req)
                    state_nxt = ST_WAKE;
            end
            ST_WAKE: begin
                if (sel_r == `OPM_SEL_SLOW && slow_stable)
                    state_nxt = ST_SLOW;
                else if (sel_r != `OPM_SEL_SLOW && hs_stable)
                    state_nxt = ST_NORMAL;
            end
            default: state_nxt = ST_WAKE;
        endcase
        if (enter_pd) begin
            case ({hs_idle_r, ls_idle_r})
                2'b00: state_nxt = ST_SLEEP;
                2'b01: state_nxt = ST_IDLE_SLOW_CLOCK_ONLY;
                2'b11: state_nxt = ST_IDLE_BOTH_CLOCKS;
                default: state_nxt = ST_IDLE2;
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn)
            state_r <= ST_WAKE;
        else
            state_r <= state_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator stabilisation
    always @* begin
        xtal_restart = 1'b0;
        if (wr_go_r && wr_addr_r == `OPM_OFS_XTAL && wr_data_r[`OPM_BIT_EN] && !xtal_en_r)
            xtal_restart = 1'b1;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            xtal_cnt_r <= {CNT_W{1'b0}};
            fast_cnt_r <= {CNT_W{1'b0}};
            slow_cnt_r <= {CNT_W{1'b0}};
        end else begin
            xtal_cnt_r <= osc_step(xtal_cnt_r, fh_on && xtal_en_r, xtal_restart, XTAL_N);
            // A frequency change restarts only a running oscillator
            fast_cnt_r <= osc_step(fast_cnt_r, fh_on && fast_en_r,
                                   fast_freq_change, FAST_N);
            slow_cnt_r <= osc_step(slow_cnt_r, fsub_on || watchdog_enable, 1'b0, SLOW_N);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers; power-down entry touches only the flags below
    always @(posedge aclk) begin
        if (!aresetn) begin
            xtal_en_r <= `OPM_XTAL_RST;
            fast_en_r <= `OPM_FAST_RST;
            ls_idle_r <= 1'b0;
            hs_idle_r <= 1'b0;
            hs_xtal_r <= 1'b0;
            sel_r <= `OPM_SEL_RST;
        end else if (wr_go_r) begin
            case (wr_addr_r)
                `OPM_OFS_XTAL: xtal_en_r <= wr_data_r[`OPM_BIT_EN];
                `OPM_OFS_FAST: fast_en_r <= wr_data_r[`OPM_BIT_EN];
                `OPM_OFS_SCC: begin
                    ls_idle_r <= wr_data_r[`OPM_BIT_LS_IDLE];
                    hs_idle_r <= wr_data_r[`OPM_BIT_HS_IDLE];
                    hs_xtal_r <= wr_data_r[`OPM_BIT_HS_XTAL];
                    sel_r <= wr_data_r[`OPM_SEL_MSB:`OPM_SEL_LSB];
                end
                default: sel_r <= sel_r;
            endcase
        end
    end

    // Set wins over clear on both flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            pdf_r <= 1'b0;
            to_r <= 1'b0;
        end else begin
            if (enter_pd)
                pdf_r <= 1'b1;
            else if (watchdog_clear_cmd)
                pdf_r <= 1'b0;
            if (watchdog_timeout)
                to_r <= 1'b1;
            else if (enter_pd)
                to_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock and oscillator outputs
    opm_clkdiv #(
        .DIV_W(6)
    ) u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(fh_on),
        .sel(sel_r),
        .tick_r(div_tick)
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            crystal_osc_enable_r <= 1'b0;
            fast_internal_osc_enable_r <= 1'b0;
            slow_internal_osc_enable_r <= 1'b0;
            fh_run_r <= 1'b0;
            fsub_run_r <= 1'b0;
            sys_clk_en_r <= 1'b0;
            cpu_hold_r <= 1'b1;
            watchdog_counter_clear_r <= 1'b0;
            sys_from_slow_r <= 1'b0;
        end else begin
            crystal_osc_enable_r <= xtal_en_r && fh_on;
            fast_internal_osc_enable_r <= fast_en_r && fh_on;
            // Watchdog keeps the slow oscillator alive whatever the idle bits say
            slow_internal_osc_enable_r <= fsub_on || watchdog_enable;
            fh_run_r <= fh_on;
            fsub_run_r <= fsub_on || watchdog_enable;
            if (state_r == ST_SLOW)
                sys_clk_en_r <= fsub_tick;
            else if (state_r == ST_NORMAL)
                sys_clk_en_r <= div_tick;
            else
                sys_clk_en_r <= 1'b0;
            // Program stays at the halt until wake and stable clock
            cpu_hold_r <= !(state_nxt == ST_NORMAL || state_nxt == ST_SLOW);
            watchdog_counter_clear_r <= enter_pd;
            // Registered from the next state so it tracks the mode register exactly
            sys_from_slow_r <= (state_nxt == ST_SLOW);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data may come in either order
    reg aw_have_r;
    reg w_have_r;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `OPM_RESP_OK;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            wr_addr_r <= {`OPM_ADDR_W{1'b0}};
            wr_data_r <= 8'h00;
            wr_go_r <= 1'b0;
        end else begin
            wr_go_r <= 1'b0;
            s_axi_awready <= !aw_have_r && !aw_take && s_axi_awvalid && !s_axi_bvalid;
            s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready)
                            && s_axi_wvalid && !s_axi_bvalid;
            if (aw_take) begin
                aw_have_r <= 1'b1;
                wr_addr_r <= {s_axi_awaddr[`OPM_ADDR_W-1:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wr_data_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            end
            if (aw_have_r && w_have_r && !s_axi_bvalid) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (wr_addr_r)
                    `OPM_OFS_XTAL, `OPM_OFS_FAST, `OPM_OFS_SCC: begin
                        s_axi_bresp <= `OPM_RESP_OK;
                        wr_go_r <= 1'b1;
                    end
                    `OPM_OFS_STAT: s_axi_bresp <= `OPM_RESP_OK;
                    default: s_axi_bresp <= `OPM_RESP_ERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `OPM_RESP_OK;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `OPM_RESP_OK;
                s_axi_rdata <= 32'h00000000;
                case ({s_axi_araddr[`OPM_ADDR_W-1:2], 2'h0})
                    `OPM_OFS_XTAL: begin
                        s_axi_rdata[`OPM_BIT_EN] <= xtal_en_r;
                        s_axi_rdata[`OPM_BIT_STABLE] <= xtal_stable;
                    end
                    `OPM_OFS_FAST: begin
                        s_axi_rdata[`OPM_BIT_EN] <= fast_en_r;
                        // Polled after leaving slow mode before trusting fH
                        s_axi_rdata[`OPM_BIT_STABLE] <= fast_stable;
                    end
                    `OPM_OFS_SCC: begin
                        s_axi_rdata[`OPM_BIT_LS_IDLE] <= ls_idle_r;
                        s_axi_rdata[`OPM_BIT_HS_IDLE] <= hs_idle_r;
                        s_axi_rdata[`OPM_BIT_HS_XTAL] <= hs_xtal_r;
                        s_axi_rdata[`OPM_SEL_MSB:`OPM_SEL_LSB] <= sel_r;
                    end
                    `OPM_OFS_STAT: begin
                        s_axi_rdata[`OPM_BIT_PDF] <= pdf_r;
                        s_axi_rdata[`OPM_BIT_TO] <= to_r;
                        s_axi_rdata[`OPM_BIT_LSTABLE] <= slow_stable;
                        s_axi_rdata[`OPM_MODE_LSB+6:`OPM_MODE_LSB] <= state_r;
                    end
                    default: s_axi_rresp <= `OPM_RESP_ERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // opm_ctrl

//--- hw/opm_map.vh
// Register map and field constants of the oscillator and operating-mode block
// What this block does
// - Watchdog enabled keeps slow oscillator running halted
// - Crystal enable clears, then sets stable flag
// - Crystal control bit 0 enables; resets 0
// - Fast frequency change re-runs stable flag
// - Fast control bit 0 enables; resets 1
// - Control bits 7 to 2 read zero
// - Select field switches speed; halt enters idle
// - Select code 111 gives slow operation
// - Slow switch waits for slow oscillator stable
// - Codes 000 to 110 give fH divided
// - Software polls stable flag after returning
// - Halt decodes idle enable bits
// - Both idle bits zero enters sleep
// - Slow idle only enters slow-clock idle
// - Power-down keeps memory, registers, ports
// - Entry sets power-down, clears timeout flag
// - Entry clears watchdog, then it resumes
// - Both idle bits one enters both-clock idle
// - Wake holds CPU until selected clock stable
`ifndef OPM_MAP_VH
`define OPM_MAP_VH

`define OPM_ADDR_W 6
`define OPM_OFS_XTAL 6'h00
`define OPM_OFS_FAST 6'h04
`define OPM_OFS_SCC 6'h08
`define OPM_OFS_STAT 6'h0C

`define OPM_BIT_EN 0
`define OPM_BIT_STABLE 1
`define OPM_XTAL_RST 1'h0
`define OPM_FAST_RST 1'h1

`define OPM_BIT_LS_IDLE 0
`define OPM_BIT_HS_IDLE 1
`define OPM_BIT_HS_XTAL 2
`define OPM_SEL_LSB 5
`define OPM_SEL_MSB 7
`define OPM_SEL_RST 3'h0
`define OPM_SEL_SLOW 3'h7

`define OPM_BIT_PDF 0
`define OPM_BIT_TO 1
`define OPM_BIT_LSTABLE 2
`define OPM_MODE_LSB 8

`define OPM_RESP_OK 2'h0
`define OPM_RESP_ERR 2'h2

`endif

//--- hw/opm_clkdiv.v
// Glitch-free fH divider producing a system clock enable tick
`timescale 1ns/1ps
`include "opm_map.vh"

module opm_clkdiv #(
    parameter DIV_W = 6
) (
    input wire aclk,
    input wire aresetn,
    input wire run,
    input wire [2:0] sel,
    output reg tick_r
);
    reg [DIV_W-1:0] cnt_r;
    reg [2:0] sel_act_r;
    wire [DIV_W-1:0] term;

    // Ratio 2**sel minus one: code 0 divides by 1, code 6 by 64
    assign term = (({{(DIV_W-1){1'b0}}, 1'b1}) << sel_act_r) - {{(DIV_W-1){1'b0}}, 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= {DIV_W{1'b0}};
            sel_act_r <= `OPM_SEL_RST;
            tick_r <= 1'b0;
        end else if (!run) begin
            cnt_r <= {DIV_W{1'b0}};
            tick_r <= 1'b0;
        end else if (cnt_r >= term) begin
            // New ratio only taken at a period boundary, so no short pulse
            cnt_r <= {DIV_W{1'b0}};
            sel_act_r <= (sel == `OPM_SEL_SLOW) ? sel_act_r : sel;
            tick_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
            tick_r <= 1'b0;
        end
    end
endmodule // opm_clkdiv

//--- dv/opm_ctrl_sva.sv
// Assertion checker for the oscillator and operating-mode block
`timescale 1ns/1ps
`include "opm_map.vh"

module opm_ctrl_chk (
    input wire aclk,
    input wire aresetn,
    input wire [`OPM_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire halt_exec,
    input wire watchdog_enable,
    input wire slow_internal_osc_enable_r,
    input wire fsub_run_r,
    input wire fh_run_r,
    input wire sys_clk_en_r,
    input wire cpu_hold_r,
    input wire watchdog_counter_clear_r
);
reg [`OPM_ADDR_W-1:0] ar_r;

// Address of the read in flight, so the answer can be judged by target
always @(posedge aclk) begin
    if (!aresetn)
        ar_r <= 6'h00;
    else if (s_axi_arvalid && s_axi_arready)
        ar_r <= {s_axi_araddr[`OPM_ADDR_W-1:2], 2'h0};
end

default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);

sequence halt_taken;
    halt_exec && !cpu_hold_r;
endsequence
sequence entry_pulse;
    watchdog_counter_clear_r ##1 !watchdog_counter_clear_r;
endsequence

halt_entry_a: assert property (halt_taken |-> ##[1:2] entry_pulse)
    else $error("halt did not clear the watchdog once");
entry_hold_a: assert property ($rose(watchdog_counter_clear_r) |-> cpu_hold_r)
    else $error("program not held on halt entry");
wdt_slow_a: assert property (watchdog_counter_clear_r && watchdog_enable
    |-> slow_internal_osc_enable_r && fsub_run_r)
    else $error("slow oscillator stopped with watchdog on");
sleep_stop_a: assert property ((cpu_hold_r && !fh_run_r && !fsub_run_r) [*2]
    |-> !sys_clk_en_r)
    else $error("system clock ticks with no source");
bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
read_answer_a: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in time");
aw_taken_a: assert property (s_axi_awready |-> s_axi_awvalid && !s_axi_bvalid)
    else $error("write address taken without request");
ctl_zero_a: assert property (s_axi_rvalid && (ar_r == `OPM_OFS_XTAL || ar_r == `OPM_OFS_FAST)
    |-> s_axi_rdata[31:2] == 30'h0000_0000)
    else $error("unimplemented control bits not zero");
unmapped_a: assert property (s_axi_rvalid && ar_r > `OPM_OFS_STAT
    |-> s_axi_rresp == `OPM_RESP_ERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule // opm_ctrl_chk

bind opm_ctrl opm_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .halt_exec(halt_exec), .watchdog_enable(watchdog_enable),
    .slow_internal_osc_enable_r(slow_internal_osc_enable_r), .fsub_run_r(fsub_run_r),
    .fh_run_r(fh_run_r), .sys_clk_en_r(sys_clk_en_r), .cpu_hold_r(cpu_hold_r),
    .watchdog_counter_clear_r(watchdog_counter_clear_r));

//--- dv/opm_testbench.sv
// Self-checking bench for the oscillator and operating-mode block
`timescale 1ns/1ps
`include "opm_map.vh"

module testbench;
reg aclk = 0;
reg aresetn = 0;
reg [5:0] awaddr = 0, araddr = 0;
reg [31:0] wdata = 0, rnd;
reg [3:0] wstrb = 0;
reg [2:0] fcnt = 0;
reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, halt_exec = 0;
reg wake_req = 0, fast_freq_change = 0, watchdog_enable = 0, watchdog_timeout = 0;
reg watchdog_clear_cmd = 0, fsub_tick = 0, ls, hs;
wire awready, wready, bvalid, arready, rvalid, sys_clk_en, cpu_hold, from_slow, fh_run, fsub_run;
wire xen, fen;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
reg [65:0] rq[$];
reg [65:0] e;
reg [1:0] bq[$];
integer errors = 0, total_checks = 0, seed = 77, k, n;

always #25 aclk = ~aclk;

// Slow oscillator stand-in: one tick every eight fast cycles
always @(posedge aclk) begin
    fcnt <= fcnt + 3'h1;
    fsub_tick <= (fcnt == 3'h7);
end

opm_ctrl #(.XTAL_STABLE_CYC(32)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .halt_exec(halt_exec), .wake_req(wake_req),
    .fast_freq_change(fast_freq_change), .watchdog_enable(watchdog_enable),
    .watchdog_timeout(watchdog_timeout), .watchdog_clear_cmd(watchdog_clear_cmd),
    .fsub_tick(fsub_tick), .crystal_osc_enable_r(xen), .fast_internal_osc_enable_r(fen),
    .slow_internal_osc_enable_r(), .fh_run_r(fh_run), .fsub_run_r(fsub_run),
    .sys_clk_en_r(sys_clk_en), .cpu_hold_r(cpu_hold), .watchdog_counter_clear_r(),
    .sys_from_slow_r(from_slow));

task chk_val(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
        errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask

task chk_resp(input [1:0] got, input [1:0] exp);
    total_checks++;
    if (got !== exp) begin
        errors++;
        $display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
    end
endtask

// Results are judged here, in the order the requests were made
always @(posedge aclk) begin
    if (rvalid && rready) begin
        e = rq.pop_front();
        chk_resp(rresp, e[65:64]);
        chk_val(rdata & e[63:32], e[31:0]);
    end
    if (bvalid && bready)
        chk_resp(bresp, bq.pop_front());
end

task axi_wr(input [5:0] a, input [31:0] d, input [1:0] er = `OPM_RESP_OK);
    integer i;
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    i = 0;
    do begin
        @(posedge aclk);
        if (awready) awvalid <= 0;
        if (wready) wvalid <= 0;
        i++;
    end while (!bvalid && i < 200);
    if (!bvalid) errors++;
    bready <= 0;
endtask

task axi_rd(input [5:0] a, input [31:0] d, input [31:0] m = 32'hFFFF_FFFF,
    input [1:0] er = `OPM_RESP_OK);
    integer i;
    rq.push_back({er, m, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    i = 0;
    do begin
        @(posedge aclk);
        if (arready) arvalid <= 0;
        i++;
    end while (!rvalid && i < 200);
    if (!rvalid) errors++;
    rready <= 0;
endtask

task wait_hold(input v);
    integer i;
    i = 0;
    while (cpu_hold !== v && i < 300) begin
        @(posedge aclk);
        i++;
    end
    chk_val(cpu_hold, v);
endtask

task cnt_ticks(input integer cyc, output integer c);
    c = 0;
    repeat (cyc) begin
        @(posedge aclk);
        if (sys_clk_en === 1'b1) c++;
    end
endtask

task wrap_up;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask

initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    wrap_up;
end

initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    wait_hold(0);
    axi_rd(`OPM_OFS_XTAL, 32'h00);
    axi_rd(`OPM_OFS_FAST, 32'h03);
    axi_rd(`OPM_OFS_STAT, 32'h0100, 32'hFF03);
    axi_rd(6'h10, 32'h0, 32'hFFFF_FFFF, `OPM_RESP_ERR);
    axi_wr(6'h10, 32'h1, `OPM_RESP_ERR);
    rnd = $random(seed);
    axi_wr(`OPM_OFS_XTAL, rnd | 32'h1);
    axi_rd(`OPM_OFS_XTAL, 32'h01);
    chk_val(xen, 1);
    repeat (40) @(posedge aclk);
    axi_rd(`OPM_OFS_XTAL, 32'h03);
    axi_wr(`OPM_OFS_XTAL, rnd & 32'hFFFF_FFFE);
    axi_rd(`OPM_OFS_XTAL, 32'h00);
    chk_val(xen, 0);
    fast_freq_change <= 1;
    @(posedge aclk);
    fast_freq_change <= 0;
    axi_rd(`OPM_OFS_FAST, 32'h01);
    repeat (30) @(posedge aclk);
    axi_rd(`OPM_OFS_FAST, 32'h03);
    for (k = 0; k < 7; k++) begin
        axi_wr(`OPM_OFS_SCC, k << 5);
        repeat (70) @(posedge aclk);
        cnt_ticks(128, n);
        chk_val(n, 128 >> k);
    end
    axi_wr(`OPM_OFS_SCC, 32'hE0);
    repeat (20) @(posedge aclk);
    chk_val(from_slow, 1);
    cnt_ticks(64, n);
    chk_val(n, 8);
    axi_rd(`OPM_OFS_STAT, 32'h0200, 32'hFF00);
    axi_wr(`OPM_OFS_SCC, 32'h00);
    repeat (40) @(posedge aclk);
    chk_val(from_slow, 0);
    axi_rd(`OPM_OFS_FAST, 32'h03);
    // Sleep with random watchdog, then with watchdog on, then the three idle modes
    for (k = 0; k < 5; k++) begin
        ls = (k == 2 || k == 3);
        hs = (k > 2);
        rnd = $random(seed);
        watchdog_enable <= (k == 1) ? 1'b1 : rnd[0];
        axi_wr(`OPM_OFS_SCC, {hs, ls});
        watchdog_timeout <= 1;
        @(posedge aclk);
        watchdog_timeout <= 0;
        axi_rd(`OPM_OFS_STAT, 32'h02, 32'h02);
        halt_exec <= 1;
        @(posedge aclk);
        halt_exec <= 0;
        wait_hold(1);
        repeat (3) @(posedge aclk);
        chk_val(fh_run, hs);
        chk_val(fsub_run, ls | watchdog_enable);
        chk_val(fen, hs);
        axi_rd(`OPM_OFS_STAT, ((k < 2 ? 4 : 4 << (k - 1)) << 8) | 1, 32'hFF03);
        wake_req <= 1;
        @(posedge aclk);
        wake_req <= 0;
        wait_hold(0);
        axi_rd(`OPM_OFS_SCC, {hs, ls});
        watchdog_clear_cmd <= 1;
        @(posedge aclk);
        watchdog_clear_cmd <= 0;
        axi_rd(`OPM_OFS_STAT, 32'h0, 32'h1);
    end
    repeat (4) @(posedge aclk);
    wrap_up;
end
endmodule // testbench
